// file: pkg/hprc_pkg.sv
package hprc_pkg;
  // =========================================
  // configuration byte fields
  localparam logic [7:0] HPRC_CFG_CMD = 8'h1c;
  localparam logic [7:0] HPRC_CFG_DEFAULT = 8'hf0;
  localparam int HPRC_BIT_KEY_OFF = 4;
  localparam int HPRC_BIT_KEY_ON = 5;
  localparam int HPRC_BIT_KEY_RESET = 6;
  localparam int HPRC_BIT_BLANK = 7;
  localparam int HPRC_BIT_PWR_INV = 0;
  localparam int HPRC_BIT_RST_INV = 1;
  // host line positions in the mode vectors
  localparam int HPRC_LINE_PWR = 1;
  localparam int HPRC_LINE_RST = 2;
  // =========================================
  // timing
  localparam int HPRC_CLK_MHZ = 125;
  localparam int HPRC_PULSE_MS = 200;
  localparam int HPRC_PULSE_CYCLES = HPRC_PULSE_MS * HPRC_CLK_MHZ * 1000;
  localparam int HPRC_WDOG_DEFAULT = 1000000;

  // =========================================
  // pin carrier
  typedef struct packed {
    logic o;
    logic oe;
  } hprc_pin_t;

  // drive modes of one host line
  typedef enum logic [0:0] {
    HPRC_MODE_HOST = 1'b0,
    HPRC_MODE_USER = 1'b1
  } hprc_mode_t;
endpackage : hprc_pkg

// file: rtl/hprc_pulse.sv
`timescale 1ns/10ps
module hprc_pulse #(
  parameter int LEN = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic invert,
  // pin
  output hprc_pkg::hprc_pin_t pin,
  output logic busy
);
  import hprc_pkg::*;

  if (LEN < 1)
  begin : g_bad_len
    $error("pulse length must be at least one cycle");
  end

  logic [31:0] cnt_reg;

  // =========================================
  // momentary drive then release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 32'h0;
      pin <= '0;
      busy <= 1'b0;
    end
    else if (!busy && start)
    begin
      cnt_reg <= 32'(LEN - 1);
      pin.oe <= 1'b1;
      pin.o <= invert;
      busy <= 1'b1;
    end
    else if (busy && cnt_reg == 32'h0)
    begin
      pin <= '0;
      busy <= 1'b0;
    end
    else if (busy)
      cnt_reg <= cnt_reg - 32'h1;
  end
endmodule : hprc_pulse

// file: rtl/hprc_top.sv
`timescale 1ns/10ps
// Contract
// (R1) the first line senses whether the host's switched supply is on and steers behaviour.
// (R2) the power-switch line stays undriven except while commanding host on or off.
// (R3) a power command drives the power line briefly low, or high if inverted, then releases it.
// (R4) the reset-switch line stays undriven unless the host is being reset.
// (R5) a reset drives the reset line briefly low, or high if inverted, then releases it.
// (R6) the watchdog expiry pulses the reset line to reset the host.
// (R7) software must keep the three host lines in their default host-control mode; the block still lets mode_we switch each line to user mode.
// (R8) after reset the three lines are in default mode, and a user command may change it.
// (R9) config value 0xf0 enables key power off, key power on, key reset and blanking while host off.
// (R10) each momentary drive lasts a fixed parameterised number of cycles.
module hprc_top #(
  parameter int PULSE_CYCLES = hprc_pkg::HPRC_PULSE_CYCLES,
  parameter int WDOG_CYCLES = hprc_pkg::HPRC_WDOG_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // configuration
  input wire logic cfg_we,
  input wire logic [7:0] cfg_cmd,
  input wire logic [7:0] cfg_data,
  input wire logic [2:0] mode_we,
  input wire logic [2:0] mode_user,
  // keypad requests
  input wire logic key_power,
  input wire logic key_reset,
  // watchdog
  input wire logic wdog_en,
  input wire logic wdog_kick,
  // host lines
  input wire logic sense_in,
  input wire logic pwr_in,
  input wire logic rst_in,
  output logic pwr_o,
  output logic pwr_oe,
  output logic hrst_o,
  output logic hrst_oe,
  // status
  output logic host_on,
  output logic blank_display,
  output logic [2:0] mode_user_state
);
  import hprc_pkg::*;

  // =========================================
  // parameter checks
  if (PULSE_CYCLES < 1)
  begin : g_bad_pulse
    $error("pulse length must be at least one cycle");
  end
  if (WDOG_CYCLES < 1)
  begin : g_bad_wdog
    $error("watchdog period must be at least one cycle");
  end

  // =========================================
  // reset release, two stages
  // release is clocked so no flop sees a runt reset edge
  logic rs1_reg;
  logic rst_n;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rs1_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rs1_reg <= 1'b1;
      rst_n <= rs1_reg;
    end
  end

  // =========================================
  // decode helpers
  // line still under host control, not handed to user gpio
  function automatic logic line_is_host(input logic [2:0] modes, input int idx);
    return modes[idx] == HPRC_MODE_HOST;
  endfunction : line_is_host

  // power key acts as off while the host is up, as on while it is down
  function automatic logic power_key_allowed(input logic [7:0] cfg, input logic up);
    return up ? cfg[HPRC_BIT_KEY_OFF] : cfg[HPRC_BIT_KEY_ON];
  endfunction : power_key_allowed

  // =========================================
  // configuration byte
  // writes with any other command byte are ignored
  logic [7:0] cfg_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_reg <= HPRC_CFG_DEFAULT; // see (R9)
    else if (cfg_we && cfg_cmd == HPRC_CFG_CMD)
      cfg_reg <= cfg_data; // see (R9)
  end

  // =========================================
  // drive modes, factory default is host control
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      mode_user_state <= {3{HPRC_MODE_HOST}}; // see (R8)
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (mode_we[i])
          mode_user_state[i] <= mode_user[i]; // see (R8)
      end
    end
  end

  // =========================================
  // host sense
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      host_on <= 1'b0;
    else
      host_on <= sense_in; // see (R1)
  end

  // blanking while the host is down
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      blank_display <= 1'b0;
    else
      blank_display <= cfg_reg[HPRC_BIT_BLANK] && !sense_in; // see (R9)
  end

  // =========================================
  // watchdog
  logic [31:0] wd_reg;
  logic wd_expire;
  logic wd_fire;

  // counts only while enabled, unkicked and the host is up
  always_comb
  begin
    wd_expire = wdog_en && !wdog_kick && sense_in && wd_reg == 32'(WDOG_CYCLES - 1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wd_reg <= 32'h0;
    else if (!wdog_en || wdog_kick || !sense_in || wd_expire)
      wd_reg <= 32'h0;
    else
      wd_reg <= wd_reg + 32'h1;
  end

  // one-cycle expiry strobe toward the reset drive
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wd_fire <= 1'b0;
    else
      wd_fire <= wd_expire; // see (R6)
  end

  // =========================================
  // request decode
  logic pwr_go;
  logic rst_cause;
  logic rst_go;

  // power press, direction chosen by host state
  always_comb
  begin
    pwr_go = key_power && line_is_host(mode_user_state, HPRC_LINE_PWR) &&
      power_key_allowed(cfg_reg, sense_in); // see (R1)
  end

  // reset press from keypad or watchdog, only while host is up
  always_comb
  begin
    rst_cause = (key_reset && cfg_reg[HPRC_BIT_KEY_RESET]) || wd_fire; // see (R6)
    rst_go = rst_cause && sense_in && line_is_host(mode_user_state, HPRC_LINE_RST); // see (R1)
  end

  // =========================================
  // momentary drives
  hprc_pin_t pwr_pin;
  hprc_pin_t rst_pin;
  // power switch press
  hprc_pulse #(.LEN(PULSE_CYCLES)) u_pwr ( // see (R10)
    .clk(clk),
    .rst_n(rst_n),
    .start(pwr_go), // see (R2)
    .invert(cfg_reg[HPRC_BIT_PWR_INV]), // see (R3)
    .pin(pwr_pin),
    .busy()
  );
  // reset switch press, shared with the watchdog
  hprc_pulse #(.LEN(PULSE_CYCLES)) u_rst ( // see (R10)
    .clk(clk),
    .rst_n(rst_n),
    .start(rst_go), // see (R4)
    .invert(cfg_reg[HPRC_BIT_RST_INV]), // see (R5)
    .pin(rst_pin),
    .busy()
  );

  // =========================================
  // outputs straight from flops inside the pulse modules
  always_comb
  begin
    pwr_o = pwr_pin.o;
    pwr_oe = pwr_pin.oe;
  end

  always_comb
  begin
    hrst_o = rst_pin.o;
    hrst_oe = rst_pin.oe;
  end
endmodule : hprc_top

// file: tb/hprc_sva.sv
`timescale 1ns/10ps
module hprc_sva (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // requests
  input wire logic key_power,
  input wire logic key_reset,
  input wire logic wdog_en,
  // host lines
  input wire logic pwr_o,
  input wire logic pwr_oe,
  input wire logic hrst_o,
  input wire logic hrst_oe,
  // status
  input wire logic host_on,
  input wire logic [2:0] mode_user_state
);
  // ==========
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_pwr_len: assert property ($rose(pwr_oe) |-> pwr_oe[*4] ##1 !pwr_oe)
    else $error("pwr pulse len");
  a_rst_len: assert property ($rose(hrst_oe) |-> hrst_oe[*4] ##1 !hrst_oe)
    else $error("rst pulse len");
  a_pwr_hold: assert property (pwr_oe && $past(pwr_oe) |-> $stable(pwr_o))
    else $error("pwr level moved");
  a_rst_hold: assert property (hrst_oe && $past(hrst_oe) |-> $stable(hrst_o))
    else $error("rst level moved");
  a_pwr_cause: assert property ($rose(pwr_oe) |-> $past(key_power))
    else $error("pwr drive uncaused");
  a_rst_cause: assert property ($rose(hrst_oe) |-> $past(key_reset) || $past(wdog_en, 2))
    else $error("rst uncaused");
  a_rst_host: assert property ($rose(hrst_oe) |-> $past(host_on))
    else $error("reset while off");
  a_pwr_mode: assert property ($rose(pwr_oe) |-> !$past(mode_user_state[1]))
    else $error("pwr in user mode");
  c_pwr_low: cover property ($rose(pwr_oe) && !pwr_o);
  c_pwr_high: cover property ($rose(pwr_oe) && pwr_o);
  c_rst_low: cover property ($rose(hrst_oe) && !hrst_o);
  c_rst_high: cover property ($rose(hrst_oe) && hrst_o);
endmodule : hprc_sva
bind hprc_top hprc_sva i_hprc_sva (.clk, .arst_n, .key_power, .key_reset, .wdog_en, .pwr_o, .pwr_oe, .hrst_o,
  .hrst_oe, .host_on, .mode_user_state);

// file: tb/hprc_host.sv
`timescale 1ns/10ps
module hprc_host (
  // clock
  input wire logic clk,
  // lines from the block
  input wire logic pwr_o,
  input wire logic pwr_oe,
  input wire logic hrst_o,
  input wire logic hrst_oe,
  // lines back to the block
  output logic pwr_in,
  output logic rst_in,
  output logic sense_in
);
  logic p_q = 1'b0;
  logic sense_q = 1'b1;
  // ==========
  // pulled-up switch inputs
  assign pwr_in = pwr_oe ? pwr_o : 1'b1;
  assign rst_in = hrst_oe ? hrst_o : 1'b1;
  assign sense_in = sense_q;
  // supply toggles when a press ends
  always @(negedge clk)
  begin
    if (p_q && !pwr_oe)
      sense_q <= !sense_q;
    p_q <= pwr_oe;
  end
endmodule : hprc_host

// file: tb/hprc_top_tb.sv
`timescale 1ns/10ps
module hprc_top_tb;
  import hprc_pkg::*;
  logic clk = 0, arst_n = 0, cfg_we = 0, kp = 0, kr = 0, wen = 0, wk = 0, pq = 0, rq = 0;
  logic [7:0] cmd = 0, dat = 0, lfsr = 8'h61;
  logic [2:0] mwe = 0, mu = 0, mus;
  logic sense, pin, rin, po, poe, ro, roe, hon, blank;
  logic [1:0] q[$];
  int n_fail = 0, samples_checked = 0;
  always #4 clk = !clk;
  hprc_top #(.PULSE_CYCLES(4), .WDOG_CYCLES(10)) i_hprc_top (.clk, .arst_n, .cfg_we, .cfg_cmd(cmd), .cfg_data(dat),
    .mode_we(mwe), .mode_user(mu), .key_power(kp), .key_reset(kr), .wdog_en(wen), .wdog_kick(wk),
    .sense_in(sense), .pwr_in(pin), .rst_in(rin), .pwr_o(po), .pwr_oe(poe), .hrst_o(ro), .hrst_oe(roe),
    .host_on(hon), .blank_display(blank), .mode_user_state(mus));
  hprc_host i_hprc_host (.clk, .pwr_o(po), .pwr_oe(poe), .hrst_o(ro), .hrst_oe(roe), .pwr_in(pin), .rst_in(rin),
    .sense_in(sense));
  function logic [7:0] nxt(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  task chk(logic [1:0] g, e);
    samples_checked++;
    if (g !== e) begin n_fail++; $display("BAD t=%0t got %h exp %h", $time, g, e); end
  endtask : chk
  task key(bit r, bit go, logic e);
    if (go) q.push_back({r, e});
    if (r) kr = 1; else kp = 1;
    @(negedge clk) {kr, kp} = 0;
    repeat (10) @(negedge clk);
  endtask : key
  task give_verdict;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // ==========
  // scoreboard
  always @(negedge clk)
  begin
    if (poe && !pq) chk({1'b0, po}, q.size() ? q.pop_front() : 2'bxx);
    if (roe && !rq) chk({1'b1, ro}, q.size() ? q.pop_front() : 2'bxx);
    pq <= poe;
    rq <= roe;
  end
  initial
  begin
    repeat (2) @(negedge clk);
    arst_n = 1;
    repeat (3) @(negedge clk);
    chk({poe, roe}, 2'b00);
    chk(mus[2:1], 2'b00);
    cfg_we = 1;
    repeat (4) begin dat = lfsr; lfsr = nxt(lfsr); @(negedge clk); end
    cfg_we = 0;
    $display("test wrong command done");
    key(0, 1, 0);
    chk({blank, hon}, 2'b10);
    key(1, 0, 0);
    key(0, 1, 0);
    chk({blank, hon}, 2'b01);
    key(1, 1, 0);
    cmd = HPRC_CFG_CMD;
    dat = 8'hf3;
    cfg_we = 1;
    @(negedge clk) cfg_we = 0;
    key(1, 1, 1);
    key(0, 1, 1);
    key(0, 1, 1);
    mwe = 3'h2;
    mu = 3'h2;
    @(negedge clk) mwe = 0;
    chk(mus[2:1], 2'b01);
    key(0, 0, 0);
    $display("test keys done");
    wen = 1;
    repeat (8) begin wk = 1; @(negedge clk) wk = 0; repeat (3) @(negedge clk); end
    chk({1'b0, roe}, 2'b00);
    q.push_back(2'b11);
    repeat (40) begin @(negedge clk); if (roe) break; end
    wen = 0;
    repeat (10) @(negedge clk);
    chk(2'(q.size()), 2'b00);
    $display("test watchdog done");
    give_verdict;
  end
  initial
  begin
    #20000;
    n_fail++;
    give_verdict;
  end
endmodule : hprc_top_tb
